/* include/ssb_cfg.svh */
// Named constants of the host-side controller for the SLIC serial bridge.
// Assumes the device's register window is byte addressed with 8-bit offsets.
`ifndef SSB_CFG_SVH
`define SSB_CFG_SVH

// Device register offsets.
`define SSB_OFS_CRG       8'h00
`define SSB_OFS_TDM_SLOTS 8'h10
`define SSB_OFS_TDM_DMA   8'h14
`define SSB_OFS_TDM_EN    8'h18
`define SSB_OFS_SPI_CTRL  8'h20
`define SSB_OFS_SPI_BAUD  8'h24
`define SSB_OFS_SPI_STAT  8'h28
`define SSB_OFS_SPI_DATA  8'h2c
`define SSB_OFS_MODE      8'h60

// Interface mode field of the mode select register.
`define SSB_MODE_TDM   2'h0
`define SSB_MODE_FOUR  2'h1
`define SSB_MODE_THREE 2'h2
`define SSB_MODE_LP_BIT 2

// Clock and reset block fields.
`define SSB_CRG_TDM_RST_BIT 0
`define SSB_CRG_BR_RST_BIT  1
`define SSB_CRG_CLK_EN_BIT  2
`define SSB_CRG_DIV_LSB     8
`define SSB_CRG_SEL_LSB     16

// SPI controller fields.
`define SSB_SPI_CPOL_BIT   8
`define SSB_SPI_CPHA_BIT   9
`define SSB_SPI_CS_LSB     12
`define SSB_SPI_EMPTY_BIT  0
`define SSB_SPI_CS_BRIDGE  2'h3
`define SSB_SPI_FRAME_FOUR 5'h08
`define SSB_SPI_FRAME_THREE 5'h09

// TDM enables and divider defaults.
`define SSB_TDM_RX_TX_EN 32'h0000_0003
`define SSB_TDM_DMA_EN   32'h0000_0001
`define SSB_DIV_THREE    8'h0c
`define SSB_DIV_FOUR     8'h06
`define SSB_SLOTS_FOUR   8'h80
`define SSB_SLOTS_THREE  8'h20
`define SSB_SPI_DIV_FOUR  8'h08
`define SSB_SPI_DIV_THREE 8'h10

// Sequence length and link beat counter width.
`define SSB_LAST_STEP 4'h9
`define SSB_BEAT_W    4
`endif

/* include/ssb_pkg.sv */
// Types shared by the host-side controller of the SLIC serial bridge.
// Assumes ssb_cfg.svh is on the include path.
package ssb_pkg;
  `include "ssb_cfg.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STEP,
    ST_WAIT_CLK,
    ST_READY,
    ST_SPI_WR,
    ST_SPI_POLL,
    ST_SPI_RD
  } ssb_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } ssb_op_type;

  typedef struct packed {
    logic [`SSB_BEAT_W-1:0] cnt;
    logic beat;
  } ssb_link_type;

  typedef struct packed {
    ssb_state_type st;
    logic [3:0] step;
    logic [1:0] mode;
    logic lp;
    logic [1:0] slic_sel;
    logic [1:0] cs;
    logic [15:0] word;
    logic req;
    logic we;
    ssb_op_type op;
    logic [15:0] rx_word;
    logic rx_valid;
    logic beat_s1;
    logic beat_s2;
    logic beat_d;
    logic clk_alive;
  } ssb_ctrl_type;
endpackage

/* core/ssb_ctrl.sv */
// Host controller that brings up the SLIC serial bridge and moves SPI words.
// Assumes the device register port answers on i_clk and that the link
// clock runs once the clock block is enabled.
//
// Contract
// RULE_01 - Device loops the receive pin to the transmit pin unsampled.
// RULE_02 - Device picks link or plain TDM from the register at 0x60.
// RULE_03 - Plain TDM mode behaves as an ordinary TDM bus.
// RULE_04 - Only one of the three pin-sharing interfaces is active.
// RULE_05 - Four-wire mode carries control and voice over four pins.
// RULE_06 - Four-wire bridge runs on 49.152 MHz with a divided TDM clock.
// RULE_07 - Four-wire SPI clock must not exceed 8.192 MHz.
// RULE_08 - Device inverts and synchronises the line interrupt.
// RULE_09 - Chip select 3 is reserved for the bridge in link modes.
// RULE_10 - Bring-up order: clocks, TDM, SPI, bridge release, TDM enable.
// RULE_11 - Select mode and start clocks while TDM and bridge are reset.
// RULE_12 - Timeslot count matches the line interface clock.
// RULE_13 - Four-wire SPI uses 8-bit frames, polarity 0, phase 0.
// RULE_14 - Three-wire bridge runs on 24 MHz with a divided TDM clock.
// RULE_15 - Three-wire SPI clock lies between 3 and 4 MHz.
// RULE_16 - Three-wire mode carries all traffic over three pins.
// RULE_17 - Three-wire TDM clock is the line clock divided by 12.
// RULE_18 - Three-wire SPI uses 9-bit frames, phase 1, polarity 0.
// RULE_19 - Three-wire writes keep bit 0 zero; reads ignore bit 0.
// RULE_20 - Three-wire SPI holds one word; wait for empty before next.
// RULE_21 - Change mode only while TDM and bridge are held in reset.
`timescale 1ns/1ps

module ssb_link_beat
  import ssb_pkg::*;
(
  // Link clock and reset
  input wire logic i_link_clk,
  input wire logic i_sys_rst,
  // Toggle that proves the link clock runs
  output logic o_beat
);
  ssb_link_type r;
  ssb_link_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.cnt = r.cnt + 1'b1;
    if (&r.cnt)
    begin
      next_r.beat = ~r.beat;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_beat = r.beat;
endmodule // ssb_link_beat

module ssb_ctrl
  import ssb_pkg::*;
#(
  parameter logic [7:0] P_SLOTS_FOUR = `SSB_SLOTS_FOUR,
  parameter logic [7:0] P_SLOTS_THREE = `SSB_SLOTS_THREE,
  parameter logic [7:0] P_DIV_FOUR = `SSB_DIV_FOUR,
  parameter logic [7:0] P_SPI_DIV_FOUR = `SSB_SPI_DIV_FOUR,
  parameter logic [7:0] P_SPI_DIV_THREE = `SSB_SPI_DIV_THREE
)
(
  // Clocks and reset
  input wire logic i_clk,
  input wire logic i_link_clk,
  input wire logic i_sys_rst,
  // User orders
  input wire logic i_start,
  input wire logic [1:0] i_mode,
  input wire logic i_loopback,
  input wire logic [1:0] i_slic_sel,
  input wire logic [1:0] i_cs,
  output logic o_ready,
  // User SPI words
  input wire logic i_spi_valid,
  input wire logic [15:0] i_spi_word,
  output logic o_spi_ready,
  output logic [15:0] o_rx_word,
  output logic o_rx_valid,
  // Device register port
  output logic o_reg_req,
  output logic o_reg_we,
  output logic [7:0] o_reg_addr,
  output logic [31:0] o_reg_wdata,
  input wire logic i_reg_ack,
  input wire logic [31:0] i_reg_rdata
);
  ssb_ctrl_type r;
  ssb_ctrl_type next_r;
  logic link_beat;

  // Clock and reset block word; resets are active while their bit is set.
  function automatic logic [31:0] crg_word(
    input logic tdm_rst,
    input logic br_rst,
    input logic clk_en,
    input logic [1:0] mode,
    input logic [1:0] sel
  );
    logic [31:0] w;
    logic [7:0] div;
    w = '0;
    div = (mode == `SSB_MODE_THREE) ? `SSB_DIV_THREE : P_DIV_FOUR; // RULE_17
    w[`SSB_CRG_TDM_RST_BIT] = tdm_rst;
    w[`SSB_CRG_BR_RST_BIT] = br_rst;
    w[`SSB_CRG_CLK_EN_BIT] = clk_en;
    w[`SSB_CRG_DIV_LSB +: 8] = div;
    w[`SSB_CRG_SEL_LSB +: 2] = sel;
    return w;
  endfunction

  // Register write issued at each bring-up step.
  function automatic ssb_op_type step_op(
    input logic [3:0] step,
    input logic [1:0] mode,
    input logic lp,
    input logic [1:0] sel,
    input logic [1:0] cs
  );
    ssb_op_type o;
    logic three;
    three = (mode == `SSB_MODE_THREE);
    o.addr = `SSB_OFS_CRG;
    o.data = '0;
    case (step)
      4'h0: o.data = crg_word(1'b1, 1'b1, 1'b0, mode, sel); // RULE_21
      4'h1:
      begin
        o.addr = `SSB_OFS_MODE; // RULE_02
        o.data[1:0] = mode;
        o.data[`SSB_MODE_LP_BIT] = lp & (mode == `SSB_MODE_TDM); // RULE_04
      end
      4'h2: o.data = crg_word(1'b1, 1'b1, 1'b1, mode, sel); // RULE_11
      4'h3: o.data = crg_word(1'b0, 1'b1, 1'b1, mode, sel); // RULE_10
      4'h4:
      begin
        o.addr = `SSB_OFS_TDM_SLOTS;
        o.data[7:0] = three ? P_SLOTS_THREE : P_SLOTS_FOUR; // RULE_12
      end
      4'h5:
      begin
        o.addr = `SSB_OFS_TDM_DMA;
        o.data = `SSB_TDM_DMA_EN;
      end
      4'h6:
      begin
        o.addr = `SSB_OFS_SPI_CTRL;
        if (three)
        begin
          o.data[4:0] = `SSB_SPI_FRAME_THREE; // RULE_18
          o.data[`SSB_SPI_CPHA_BIT] = 1'b1;
        end
        else
        begin
          o.data[4:0] = `SSB_SPI_FRAME_FOUR; // RULE_13
        end
        o.data[`SSB_SPI_CS_LSB +: 2] = (mode == `SSB_MODE_TDM) ? cs
                                     : `SSB_SPI_CS_BRIDGE; // RULE_09
      end
      4'h7:
      begin
        o.addr = `SSB_OFS_SPI_BAUD; // RULE_07
        o.data[7:0] = three ? P_SPI_DIV_THREE : P_SPI_DIV_FOUR; // RULE_15
      end
      4'h8: o.data = crg_word(1'b0, 1'b0, 1'b1, mode, sel); // RULE_10
      4'h9:
      begin
        o.addr = `SSB_OFS_TDM_EN;
        o.data = `SSB_TDM_RX_TX_EN;
      end
      default: o.data = crg_word(1'b1, 1'b1, 1'b0, mode, sel);
    endcase
    return o;
  endfunction

  ssb_link_beat u_beat (
    .i_link_clk(i_link_clk),
    .i_sys_rst(i_sys_rst),
    .o_beat(link_beat)
  );

  always_comb
  begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.beat_s1 = link_beat;
    next_r.beat_s2 = r.beat_s1;
    next_r.beat_d = r.beat_s2;
    if (r.req && i_reg_ack)
    begin
      next_r.req = 1'b0;
    end
    case (r.st)
      ST_IDLE:
      begin
        if (i_start)
        begin
          next_r.mode = i_mode;
          next_r.lp = i_loopback;
          next_r.slic_sel = i_slic_sel;
          next_r.cs = i_cs;
          next_r.step = '0;
          next_r.req = 1'b1;
          next_r.we = 1'b1;
          next_r.op = step_op(4'h0, i_mode, i_loopback, i_slic_sel, i_cs);
          next_r.st = ST_STEP;
        end
      end
      ST_STEP:
      begin
        if (r.req && i_reg_ack)
        begin
          if (r.step == `SSB_LAST_STEP)
          begin
            next_r.st = ST_READY;
          end
          else if (r.step == 4'h2)
          begin
            next_r.clk_alive = 1'b0;
            next_r.st = ST_WAIT_CLK; // RULE_11
          end
          else
          begin
            next_r.step = r.step + 4'h1;
            next_r.req = 1'b1;
            next_r.op = step_op(r.step + 4'h1, r.mode, r.lp, r.slic_sel, r.cs);
          end
        end
      end
      ST_WAIT_CLK:
      begin
        if (r.clk_alive)
        begin
          next_r.step = 4'h3;
          next_r.req = 1'b1;
          next_r.op = step_op(4'h3, r.mode, r.lp, r.slic_sel, r.cs); // RULE_10
          next_r.st = ST_STEP;
        end
      end
      ST_READY:
      begin
        if (i_start)
        begin
          next_r.st = ST_IDLE; // RULE_21
        end
        else if (i_spi_valid)
        begin
          next_r.word = i_spi_word;
          if (r.mode == `SSB_MODE_THREE)
          begin
            next_r.word[0] = 1'b0; // RULE_19
          end
          next_r.st = ST_SPI_WR;
        end
      end
      ST_SPI_WR:
      begin
        if (!r.req)
        begin
          next_r.req = 1'b1;
          next_r.we = 1'b1;
          next_r.op.addr = `SSB_OFS_SPI_DATA;
          next_r.op.data = {16'h0000, r.word};
          next_r.st = ST_SPI_POLL;
        end
      end
      ST_SPI_POLL:
      begin
        if (!r.req)
        begin
          next_r.req = 1'b1;
          next_r.we = 1'b0;
          next_r.op.addr = `SSB_OFS_SPI_STAT;
          next_r.op.data = '0;
        end
        else if (i_reg_ack && !r.we &&
                 i_reg_rdata[`SSB_SPI_EMPTY_BIT])
        begin
          next_r.op.addr = `SSB_OFS_SPI_DATA; // RULE_20
          next_r.req = 1'b1;
          next_r.st = ST_SPI_RD;
        end
      end
      ST_SPI_RD:
      begin
        if (r.req && i_reg_ack)
        begin
          next_r.rx_word = i_reg_rdata[15:0];
          if (r.mode == `SSB_MODE_THREE)
          begin
            next_r.rx_word[0] = 1'b0; // RULE_19
          end
          next_r.rx_valid = 1'b1;
          next_r.we = 1'b1;
          next_r.st = ST_READY;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    if (r.beat_s2 != r.beat_d)
    begin
      next_r.clk_alive = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_ready = (r.st == ST_READY);
  assign o_spi_ready = (r.st == ST_READY) && !i_start;
  assign o_rx_word = r.rx_word;
  assign o_rx_valid = r.rx_valid;
  assign o_reg_req = r.req;
  assign o_reg_we = r.we;
  assign o_reg_addr = r.op.addr;
  assign o_reg_wdata = r.op.data;
endmodule // ssb_ctrl

/* testbench/ssb_ctrl_monitor.sv */
// Checker of the register traffic issued by the bridge controller.
// Assumes it is bound to ssb_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module ssb_ctrl_monitor
  import ssb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Device register port
  input wire logic o_reg_req,
  input wire logic o_reg_we,
  input wire logic [7:0] o_reg_addr,
  input wire logic [31:0] o_reg_wdata,
  input wire logic i_reg_ack,
  input wire logic [31:0] i_reg_rdata
);
  logic [31:0] crg;
  logic [1:0] md;
  logic pend;
  logic wv;
  assign wv = o_reg_req && o_reg_we;
  // Shadows of the last clock block word, mode and SPI word in flight.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      crg <= 32'h0;
      md <= 2'h0;
      pend <= 1'b0;
    end
    else if (o_reg_req && i_reg_ack)
    begin
      if (wv && o_reg_addr == 8'h00)
        crg <= o_reg_wdata;
      if (wv && o_reg_addr == 8'h60)
        md <= o_reg_wdata[1:0];
      if (wv && o_reg_addr == 8'h2c)
        pend <= 1'b1;
      if (!o_reg_we && o_reg_addr == 8'h28 && i_reg_rdata[0])
        pend <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_req_held: assert property (o_reg_req && !i_reg_ack |=> o_reg_req
    && $stable(o_reg_addr) && $stable(o_reg_wdata) && $stable(o_reg_we))
    else $error("request changed before ack");
  a_mode_in_reset: assert property (wv && o_reg_addr == 8'h60 |->
    crg[1:0] == 2'h3 && o_reg_wdata[1:0] != 2'h3)
    else $error("mode written outside reset");
  a_enable_order: assert property (wv && o_reg_addr == 8'h18 |->
    crg[2:0] == 3'h4)
    else $error("tdm enabled before bridge release");
  a_cs_reserved: assert property (wv && o_reg_addr == 8'h20
    && md != 2'h0 |-> o_reg_wdata[13:12] == 2'h3)
    else $error("link mode without chip select 3");
  a_frame_four: assert property (wv && o_reg_addr == 8'h20
    && md == 2'h1 |-> o_reg_wdata[4:0] == 5'h08 && o_reg_wdata[9:8] == 2'h0)
    else $error("four wire spi format wrong");
  a_frame_three: assert property (wv && o_reg_addr == 8'h20
    && md == 2'h2 |-> o_reg_wdata[4:0] == 5'h09 && o_reg_wdata[9:8] == 2'h2)
    else $error("three wire spi format wrong");
  a_div_three: assert property (wv && o_reg_addr == 8'h00
    && md == 2'h2 && o_reg_wdata[2] |-> o_reg_wdata[15:8] == 8'h0c)
    else $error("three wire divider wrong");
  a_lsb_zero: assert property (wv && o_reg_addr == 8'h2c
    && md == 2'h2 |-> !o_reg_wdata[0])
    else $error("three wire word with bit 0 set");
  a_one_word: assert property (wv && o_reg_addr == 8'h2c |-> !pend)
    else $error("spi word written before fifo empty");
endmodule // ssb_ctrl_monitor

bind ssb_ctrl ssb_ctrl_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .o_reg_req(o_reg_req), .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr),
  .o_reg_wdata(o_reg_wdata), .i_reg_ack(i_reg_ack),
  .i_reg_rdata(i_reg_rdata));

/* testbench/ssb_dev_model.sv */
// Behavioural model of the device registers behind the controller.
// Assumes one request at a time, held until it is acknowledged.
`timescale 1ns/1ps
module ssb_dev_model
  import ssb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [2:0] i_lat,
  output logic o_ack,
  output logic [31:0] o_rdata,
  // Remote loopback pins
  input wire logic i_tdm_rx,
  output logic o_tdm_tx
);
  logic [31:0] regs [256];
  logic [7:0] wr_q [$];
  logic [2:0] cnt;
  logic [1:0] polls;
  logic [31:0] rd;
  // Read data is only meaningful together with the acknowledge.
  assign o_rdata = o_ack ? rd : ~rd;
  // The receive pin reaches the transmit pin through no flop.
  assign o_tdm_tx = regs[8'h60][2:0] == 3'h4 ? i_tdm_rx : 1'b0;
  always @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_ack <= 1'b0;
      cnt <= 3'h0;
      polls <= 2'h0;
    end
    else if (o_ack)
      o_ack <= 1'b0;
    else if (i_req && cnt < i_lat)
      cnt <= cnt + 3'h1;
    else if (i_req)
    begin
      o_ack <= 1'b1;
      cnt <= 3'h0;
      rd <= regs[i_addr];
      if (i_we)
      begin
        regs[i_addr] <= i_wdata;
        wr_q.push_back(i_addr);
      end
      if (i_we && i_addr == 8'h2c)
        polls <= 2'h0;
      // The FIFO first reports empty on the third status read.
      if (!i_we && i_addr == 8'h28)
      begin
        rd <= {31'h0, polls[1]};
        polls <= polls[1] ? polls : polls + 2'h1;
      end
    end
  end
endmodule // ssb_dev_model

/* testbench/ssb_ctrl_tb.sv */
// Self-checking bench of the bridge controller against a device model.
// Assumes the package, the controller and the model are compiled first.
`timescale 1ns/1ps
module ssb_ctrl_tb
  import ssb_pkg::*;
;
  logic i_clk, lclk, i_sys_rst, start, loop, ready, spi_rdy, rx_valid;
  logic valid, req, we, ack, tdm_tx;
  logic [1:0] mode, sel, cs;
  logic [2:0] lat;
  logic [7:0] addr;
  logic [15:0] word, rx_word;
  logic [31:0] wdata, rdata, seed, r;
  logic [15:0] exp_q [$];
  int error_cnt, total_checks;

  ssb_ctrl i_dut (.i_clk(i_clk), .i_link_clk(lclk), .i_sys_rst(i_sys_rst),
    .i_start(start), .i_mode(mode), .i_loopback(loop), .i_slic_sel(sel),
    .i_cs(cs), .o_ready(ready), .i_spi_valid(valid), .i_spi_word(word),
    .o_spi_ready(spi_rdy), .o_rx_word(rx_word), .o_rx_valid(rx_valid),
    .o_reg_req(req), .o_reg_we(we), .o_reg_addr(addr), .o_reg_wdata(wdata),
    .i_reg_ack(ack), .i_reg_rdata(rdata));
  ssb_dev_model i_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
    .i_we(we), .i_addr(addr), .i_wdata(wdata), .i_lat(lat), .o_ack(ack),
    .o_rdata(rdata), .i_tdm_rx(seed[0]), .o_tdm_tx(tdm_tx));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 2000)
    begin
      @(posedge i_clk);
      n++;
    end
    check(32'(n < 2000), 32'h1);
  endtask

  task automatic bring_up(input logic [1:0] m);
    logic [7:0] ea [10] = '{8'h00, 8'h60, 8'h00, 8'h00, 8'h10, 8'h14,
      8'h20, 8'h24, 8'h00, 8'h18};
    i_dev.wr_q.delete();
    r = rnd();
    @(posedge i_clk);
    mode <= m;
    loop <= r[0];
    sel <= r[2:1];
    cs <= r[4:3];
    lat <= r[7:5];
    start <= 1'b1;
    @(posedge i_clk);
    start <= 1'b0;
    wait_hi(ready);
    check(32'(i_dev.wr_q.size()), 32'd10);
    foreach (ea[k])
      check(32'(i_dev.wr_q[k]), 32'(ea[k]));
    check(32'(i_dev.regs[8'h60][2:0]), 32'({m == 2'h0 && loop, m}));
    check(i_dev.regs[8'h18], 32'h3);
    if (m == 2'h0)
      check(32'(tdm_tx), 32'(loop & seed[0]));
    if (m != 2'h0)
    begin
      r = i_dev.regs[8'h20];
      check({r[13:8], r[4:0]}, {2'h3, 2'h0, m == 2'h2, 1'b0,
        m == 2'h2 ? 5'h09 : 5'h08});
      check(32'(i_dev.regs[8'h10][7:0]),
        m == 2'h2 ? 32'h20 : 32'h80);
      check(32'(i_dev.regs[8'h24][7:0]),
        m == 2'h2 ? 32'h10 : 32'h08);
      r = i_dev.regs[8'h00];
      check({r[17:8], r[2:0]},
        {sel, m == 2'h2 ? 8'h0c : 8'h06, 3'h4});
    end
  endtask

  task automatic send(input logic [1:0] m);
    r = rnd();
    wait_hi(spi_rdy);
    valid <= 1'b1;
    word <= r[15:0];
    exp_q.push_back({r[15:1], r[0] && m != 2'h2});
    @(posedge i_clk);
    valid <= 1'b0;
    wait_hi(rx_valid);
    @(posedge i_clk);
  endtask

  // Results are compared away from the edge that updates them.
  always @(negedge i_clk)
    if (rx_valid === 1'b1)
      check(32'(rx_word), 32'(exp_q.pop_front()));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial
  begin
    lclk = 1'b0;
    #7;
    forever #62.5 lclk = ~lclk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    seed = 32'h1cbd7336;
    {i_sys_rst, start, loop, valid, mode, sel, cs, lat, word} = 29'h10000000;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 2; k++)
      for (int m = 1; m < 4; m++)
      begin
        bring_up(2'(m % 3));
        repeat (3) send(2'(m % 3));
        @(posedge i_clk);
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
      end
    close_out();
  end
endmodule // ssb_ctrl_tb
